// ### src/esps_pkg.sv
package esps_pkg;

    // Register offsets on the four address lines
    localparam logic [3:0] ESPS_OFS_CMD = 4'h0;
    localparam logic [3:0] ESPS_OFS_FLAGS = 4'h7;
    localparam logic [3:0] ESPS_OFS_MASK = 4'hf;

    // Bank codes carried by the two bank-select bits
    localparam logic [1:0] ESPS_BANK0 = 2'h0;
    localparam logic [1:0] ESPS_BANK1 = 2'h1;
    localparam logic [1:0] ESPS_BANK2 = 2'h2;
    localparam logic [1:0] ESPS_BANK_RSVD = 2'h3;

    // Field positions in the command register
    localparam int ESPS_CMD_HALT = 0;
    localparam int ESPS_CMD_ACT = 1;
    localparam int ESPS_CMD_BANK_LO = 6;
    localparam int ESPS_CMD_BANK_HI = 7;

    // Field positions in the event flags register
    localparam int ESPS_FLG_RX_OK = 0;
    localparam int ESPS_FLG_TX_OK = 1;
    localparam int ESPS_FLG_RX_ERR = 2;
    localparam int ESPS_FLG_TX_ERR = 3;
    localparam int ESPS_FLG_RING = 4;
    localparam int ESPS_FLG_TALLY = 5;
    localparam int ESPS_FLG_RDONE = 6;
    localparam int ESPS_FLG_RST = 7;

    // Reset values
    localparam logic [7:0] ESPS_CMD_RST = 8'h01;
    localparam logic [7:0] ESPS_FLAGS_RST = 8'h00;
    localparam logic [7:0] ESPS_MASK_RST = 8'h00;
    localparam logic [13:0] ESPS_HOST_RST = 14'h0000;

    // Host pin group, sampled through the synchroniser
    typedef struct packed {
        logic rd;
        logic wr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } esps_host_t;

    // Event pulses from the controller core, same clock
    typedef struct packed {
        logic rx_ok;
        logic tx_ok;
        logic rx_crc_err;
        logic rx_align_err;
        logic rx_fifo_overrun;
        logic rx_missed;
        logic tx_excess_coll;
        logic tx_fifo_underrun;
        logic ring_boundary_hit;
        logic tally_msb_set;
        logic remote_done;
        logic ring_overflow;
        logic ring_packet_removed;
        logic core_idle;
    } esps_evt_t;

endpackage

// ### src/esps_sync.sv
`timescale 1ns/1ns
`default_nettype none
module esps_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ### src/esps_event_status.sv
`timescale 1ns/1ns
`default_nettype none
module esps_event_status (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Host register port pins
    input wire esps_pkg::esps_host_t host_pins,
    output logic [7:0] host_rdata_q,
    output logic host_rdata_oe_q,
    // Controller core events
    input wire esps_pkg::esps_evt_t core_evt,
    // Status to host and core
    output logic irq_q,
    output logic [7:0] command_register_q,
    output logic [1:0] bank_sel_q
);
    import esps_pkg::*;

    esps_host_t host_s;
    logic wr_s_q;
    logic rd_s_q;
    logic wr_stb;
    logic rd_stb;
    logic wr_cmd;
    logic wr_flags;
    logic wr_mask;
    logic [7:0] event_cause_flags_q;
    logic [7:0] event_cause_flags_d;
    logic [7:0] event_enable_mask_q;
    logic [7:0] set_vec;
    logic [7:0] rd_mux;
    logic rst_set;
    logic rst_clr;

    esps_sync #(
        .WIDTH($bits(esps_host_t))
    ) u_host_sync (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .async_in(host_pins),
        .sync_out(host_s)
    );

    // Strobe edges on the synchronised pins
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wr_s_q <= 1'b0;
            rd_s_q <= 1'b0;
        end
        else
        begin
            wr_s_q <= host_s.wr;
            rd_s_q <= host_s.rd;
        end
    end

    assign wr_stb = host_s.wr & ~wr_s_q;
    assign rd_stb = host_s.rd & ~rd_s_q;

    // Command register reachable in every bank; others written in bank 0
    assign wr_cmd = wr_stb && host_s.addr == ESPS_OFS_CMD;
    assign wr_flags = wr_stb && host_s.addr == ESPS_OFS_FLAGS
        && bank_sel_q == ESPS_BANK0;
    assign wr_mask = wr_stb && host_s.addr == ESPS_OFS_MASK
        && bank_sel_q == ESPS_BANK0;

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            command_register_q <= ESPS_CMD_RST;
        else if (wr_cmd)
            command_register_q <= host_s.wdata;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            bank_sel_q <= ESPS_BANK0;
        else if (wr_cmd)
            bank_sel_q <=
                host_s.wdata[ESPS_CMD_BANK_HI:ESPS_CMD_BANK_LO];
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            event_enable_mask_q <= ESPS_MASK_RST;
        else if (wr_mask)
            event_enable_mask_q <= host_s.wdata;
    end

    always_comb
    begin
        set_vec = 8'h00;
        set_vec[ESPS_FLG_RX_OK] = core_evt.rx_ok;
        set_vec[ESPS_FLG_TX_OK] = core_evt.tx_ok;
        set_vec[ESPS_FLG_RX_ERR] = core_evt.rx_crc_err
            | core_evt.rx_align_err | core_evt.rx_fifo_overrun
            | core_evt.rx_missed;
        set_vec[ESPS_FLG_TX_ERR] = core_evt.tx_excess_coll
            | core_evt.tx_fifo_underrun;
        set_vec[ESPS_FLG_RING] = core_evt.ring_boundary_hit;
        set_vec[ESPS_FLG_TALLY] = core_evt.tally_msb_set;
        set_vec[ESPS_FLG_RDONE] = core_evt.remote_done;
    end

    // Reset indicator: halted and idle, or ring overflow
    // A write that lifts halt leaves the reset state on its own edge,
    // so the start command is not overridden by the old halt level
    assign rst_set = (command_register_q[ESPS_CMD_HALT]
        & ~(wr_cmd & ~host_s.wdata[ESPS_CMD_HALT]) & core_evt.core_idle)
        | core_evt.ring_overflow;
    assign rst_clr = (wr_cmd & host_s.wdata[ESPS_CMD_ACT])
        | core_evt.ring_packet_removed;

    always_comb
    begin
        event_cause_flags_d = event_cause_flags_q;
        if (wr_flags)
            event_cause_flags_d[6:0] = event_cause_flags_q[6:0]
                & ~host_s.wdata[6:0];
        event_cause_flags_d[6:0] = event_cause_flags_d[6:0]
            | set_vec[6:0];
        if (rst_set)
            event_cause_flags_d[ESPS_FLG_RST] = 1'b1;
        else if (rst_clr)
            event_cause_flags_d[ESPS_FLG_RST] = 1'b0;
    end

    // Flags start clear; host still clears them after power-up
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            event_cause_flags_q <= ESPS_FLAGS_RST;
        else
            event_cause_flags_q <= event_cause_flags_d;
    end

    // Bit 7 is left out of the interrupt term
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            irq_q <= 1'b0;
        else
            irq_q <= |(event_cause_flags_q[6:0]
                & event_enable_mask_q[6:0]);
    end

    always_comb
    begin
        rd_mux = 8'h00;
        if (host_s.addr == ESPS_OFS_CMD)
            rd_mux = command_register_q;
        else if (bank_sel_q == ESPS_BANK0 && host_s.addr == ESPS_OFS_FLAGS)
            rd_mux = event_cause_flags_q;
        else if (bank_sel_q == ESPS_BANK2 && host_s.addr == ESPS_OFS_MASK)
            rd_mux = event_enable_mask_q;
    end

    // Read data held from the strobe edge until the strobe drops
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            host_rdata_q <= 8'h00;
            host_rdata_oe_q <= 1'b0;
        end
        else if (rd_stb)
        begin
            host_rdata_q <= rd_mux;
            host_rdata_oe_q <= 1'b1;
        end
        else if (!host_s.rd)
            host_rdata_oe_q <= 1'b0;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    a_irq_tracks_flags: assert property (
        |(event_cause_flags_q[6:0] & event_enable_mask_q[6:0]) |=> irq_q)
        else $error("interrupt low while an enabled flag is set");

    a_irq_release: assert property (
        (event_cause_flags_q[6:0] & event_enable_mask_q[6:0]) == 7'h00
        |=> !irq_q)
        else $error("interrupt high with no enabled flag set");

    a_clear_by_one: assert property (
        wr_flags && host_s.wdata[ESPS_FLG_RX_OK] && !core_evt.rx_ok
        |=> !event_cause_flags_q[ESPS_FLG_RX_OK])
        else $error("writing one did not clear the flag");

    a_zero_keeps: assert property (
        wr_flags && !host_s.wdata[ESPS_FLG_TX_OK]
        |=> event_cause_flags_q[ESPS_FLG_TX_OK]
            == $past(event_cause_flags_q[ESPS_FLG_TX_OK])
            || $past(core_evt.tx_ok))
        else $error("writing zero changed a flag");

    a_set_wins_clear: assert property (
        core_evt.tx_excess_coll || core_evt.tx_fifo_underrun
        |=> event_cause_flags_q[ESPS_FLG_TX_ERR])
        else $error("transmit error event lost");

    a_rx_err_sets: assert property (
        core_evt.rx_missed ##1 1'b1
        |-> event_cause_flags_q[ESPS_FLG_RX_ERR])
        else $error("receive error flag not set");

    a_rst_on_halt: assert property (
        command_register_q[ESPS_CMD_HALT] && core_evt.core_idle
        && !(wr_cmd && !host_s.wdata[ESPS_CMD_HALT])
        |=> event_cause_flags_q[ESPS_FLG_RST])
        else $error("reset indicator not set in halt");

    a_rst_start_clears: assert property (
        wr_cmd && host_s.wdata[ESPS_CMD_ACT] && !host_s.wdata[ESPS_CMD_HALT]
        && !core_evt.ring_overflow |=> !event_cause_flags_q[ESPS_FLG_RST])
        else $error("start command did not clear the reset indicator");

    a_rst_write_ignored: assert property (
        wr_flags && !rst_set && !rst_clr
        |=> $stable(event_cause_flags_q[ESPS_FLG_RST]))
        else $error("host write changed the reset indicator");

    a_rst_no_irq: assert property (
        event_cause_flags_q == 8'h80 |=> !irq_q)
        else $error("reset indicator raised the interrupt");

    a_mask_gates: assert property (
        event_enable_mask_q[6:0] == 7'h00 ##1
        event_enable_mask_q[6:0] == 7'h00 |-> !irq_q)
        else $error("interrupt raised with every enable off");

    a_bank_decode: assert property (
        wr_cmd |=> bank_sel_q
            == $past(host_s.wdata[ESPS_CMD_BANK_HI:ESPS_CMD_BANK_LO]))
        else $error("bank select not taken from command write");
endmodule
`default_nettype wire

// ### bench/esps_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module esps_host_model (
    // Clock
    input wire logic core_clk,
    // Register port
    output var esps_pkg::esps_host_t host_pins,
    input wire logic [7:0] host_rdata_q,
    input wire logic host_rdata_oe_q
);
    import esps_pkg::*;
    int n;
    initial host_pins = ESPS_HOST_RST;
    // Strobe held until the write has landed, then a gap before the next
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        host_pins.addr <= a;
        host_pins.wdata <= d;
        host_pins.wr <= 1'b1;
        repeat (5) @(posedge core_clk);
        host_pins.wr <= 1'b0;
        host_pins.wdata <= ~d; // Released bus must not hold a stale value
        repeat (3) @(posedge core_clk);
    endtask
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        host_pins.addr <= a;
        host_pins.rd <= 1'b1;
        n = 0;
        do @(posedge core_clk); while (host_rdata_oe_q !== 1'b1 && ++n < 12);
        d = host_rdata_q;
        host_pins.rd <= 1'b0;
        n = 0;
        do @(posedge core_clk); while (host_rdata_oe_q !== 1'b0 && ++n < 12);
        repeat (2) @(posedge core_clk);
    endtask
    task automatic sel_bank(input logic [1:0] b);
        if (b != ESPS_BANK_RSVD)
            wr_reg(ESPS_OFS_CMD, {b, 6'h01});
    endtask
    task automatic clear_all;
        wr_reg(ESPS_OFS_FLAGS, 8'hff);
    endtask
    // Stop, then poll until the reset indicator confirms it
    task automatic wait_halt(output logic [7:0] d);
        wr_reg(ESPS_OFS_CMD, 8'h01);
        d = 8'h00;
        for (int i = 0; i < 8 && d[ESPS_FLG_RST] !== 1'b1; i++)
            rd_reg(ESPS_OFS_FLAGS, d);
    endtask
endmodule
`default_nettype wire

// ### bench/event_status_and_page_select_bench.sv
`timescale 1ns/1ns
`default_nettype none
module event_status_and_page_select_bench;
    import esps_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    esps_evt_t core_evt = '0;
    esps_host_t host_pins;
    logic [7:0] host_rdata_q;
    logic host_rdata_oe_q;
    logic irq_q;
    logic [7:0] cmd_q;
    logic [1:0] bank_sel_q;
    logic [7:0] rd_v;
    int n_mismatch = 0;
    int check_count = 0;
    // Event pulse beside the flag byte it should leave
    localparam logic [21:0] ROWS [12] = '{
        {14'h2000, 8'h01}, {14'h1000, 8'h02}, {14'h0800, 8'h04},
        {14'h0400, 8'h04}, {14'h0200, 8'h04}, {14'h0100, 8'h04},
        {14'h0900, 8'h04}, {14'h0080, 8'h08}, {14'h0040, 8'h08},
        {14'h0020, 8'h10}, {14'h0010, 8'h20}, {14'h0008, 8'h40}};
    always #25 core_clk = ~core_clk;
    esps_event_status dut (
        .core_clk(core_clk), .arst_n(arst_n), .host_pins(host_pins),
        .host_rdata_q(host_rdata_q), .host_rdata_oe_q(host_rdata_oe_q),
        .core_evt(core_evt), .irq_q(irq_q), .command_register_q(cmd_q),
        .bank_sel_q(bank_sel_q));
    esps_host_model host (
        .core_clk(core_clk), .host_pins(host_pins),
        .host_rdata_q(host_rdata_q), .host_rdata_oe_q(host_rdata_oe_q));
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h0, got}, {7'h0, exp});
    endtask
    task automatic test_done;
        if (n_mismatch == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic pulse(input esps_evt_t e);
        @(posedge core_clk);
        core_evt <= e | {13'h0, core_evt.core_idle};
        @(posedge core_clk);
        core_evt <= {13'h0, core_evt.core_idle};
        repeat (3) @(posedge core_clk);
    endtask
    task automatic flags_are(input logic [7:0] exp);
        host.rd_reg(ESPS_OFS_FLAGS, rd_v);
        chk8(rd_v, exp);
    endtask
    initial
    begin
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        host.rd_reg(ESPS_OFS_CMD, rd_v);
        chk8(rd_v, ESPS_CMD_RST);
        host.clear_all();
        pulse(14'h2000);
        chk1(irq_q, 1'b0);
        host.wr_reg(ESPS_OFS_FLAGS, 8'h00);
        flags_are(8'h01);
        host.wr_reg(ESPS_OFS_MASK, 8'h7f);
        chk1(irq_q, 1'b1);
        host.clear_all();
        for (int i = 0; i < 12; i++)
        begin
            pulse(ROWS[i][21:8]);
            chk1(irq_q, 1'b1);
            flags_are(ROWS[i][7:0]);
            host.clear_all();
            chk1(irq_q, 1'b0);
        end
        pulse(14'h3000);
        host.sel_bank(ESPS_BANK1);
        flags_are(8'h00);
        host.sel_bank(ESPS_BANK2);
        chk8({6'h00, bank_sel_q}, {6'h00, ESPS_BANK2});
        host.rd_reg(ESPS_OFS_MASK, rd_v);
        chk8(rd_v, 8'h7f);
        host.sel_bank(ESPS_BANK0);
        flags_are(8'h03);
        host.wr_reg(ESPS_OFS_FLAGS, 8'h01);
        chk1(irq_q, 1'b1);
        host.wr_reg(ESPS_OFS_FLAGS, 8'h02);
        chk1(irq_q, 1'b0);
        // Event lands in the cycle in which the synced clear acts
        fork
            host.wr_reg(ESPS_OFS_FLAGS, 8'hff);
            begin
                repeat (2) @(posedge core_clk);
                pulse(14'h2000);
            end
        join
        flags_are(8'h01);
        host.clear_all();
        @(posedge core_clk);
        core_evt.core_idle <= 1'b1;
        host.wr_reg(ESPS_OFS_MASK, 8'hff);
        host.wait_halt(rd_v);
        chk8(rd_v, 8'h80);
        chk1(irq_q, 1'b0);
        host.clear_all();
        flags_are(8'h80);
        host.wr_reg(ESPS_OFS_CMD, 8'h02);
        chk8(cmd_q, 8'h02);
        flags_are(8'h00);
        pulse(14'h0005);
        flags_are(8'h80);
        host.clear_all();
        flags_are(8'h80);
        pulse(14'h0003);
        flags_are(8'h00);
        test_done();
    end
    initial
    begin
        #500000;
        n_mismatch++;
        test_done();
    end
endmodule
`default_nettype wire
